// File: hw/udei_pkg.sv
// Constants, field layout and carrier types of the USB device event block.
//
// Overview of operation
// RULE1 - Latch frame number from SOF, clear on bus reset.
// RULE2 - Flag corrupted SOF frame number, clear on reset.
// RULE3 - CRC flag updates together with SOF status.
// RULE4 - Enable layout: DMA 25-30, endpoints 8-14, events 1-7.
// RULE5 - Bus reset leaves only end-of-reset enabled.
// RULE6 - Status bit 0 shows high speed.
// RULE7 - Suspend status after 3 ms idle J.
// RULE8 - Enable gates interrupt, never status latching; endpoint and DMA status latch only their enabled sources.
// RULE9 - Micro SOF sets status, increments microframe count.
// RULE10 - SOF sets status; high speed clears microframe count.
// RULE11 - SOF and micro SOF never both per packet.
// RULE12 - End of bus reset sets its status.
// RULE13 - Non-idle line in suspend sets wake-up.
// RULE14 - Wake-up detection runs on always-on clock.
// RULE15 - Software re-enables controller clock after wake-up.
// RULE16 - Host resume end sets its status.
// RULE17 - Own upstream resume sets its status.
// RULE18 - Endpoint status follows enabled source, reset clears.
// RULE19 - DMA status follows enabled channel source.
// RULE20 - Clear register writes one to clear events.
// RULE21 - Endpoint reset register, one strobe per endpoint.
// RULE22 - Endpoint reset strobe clears endpoint state.
// RULE23 - Microframe count 0 to 7, restarts each frame.
// RULE24 - Interrupt is OR of enabled sources.
package udei_pkg;

    // ------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------
    localparam logic [31:0] ADDR_FNUM = 32'hF803C004;
    localparam logic [31:0] ADDR_IEN = 32'hF803C010;
    localparam logic [31:0] ADDR_ISTA = 32'hF803C014;
    localparam logic [31:0] ADDR_ICLR = 32'hF803C018;
    localparam logic [31:0] ADDR_EPRST = 32'hF803C01C;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int SPEED_BIT = 0;
    localparam int SUSP_BIT = 1;
    localparam int USOF_BIT = 2;
    localparam int SOF_BIT = 3;
    localparam int ENDRST_BIT = 4;
    localparam int WAKE_BIT = 5;
    localparam int ENDRSM_BIT = 6;
    localparam int UPRES_BIT = 7;
    localparam int EP_LSB = 8;
    localparam int EP_COUNT = 7;
    localparam int DMA_LSB = 25;
    localparam int DMA_COUNT = 6;
    localparam int UFRM_LSB = 0;
    localparam int UFRM_W = 3;
    localparam int FNUM_LSB = 3;
    localparam int FNUM_W = 11;
    localparam int FERR_BIT = 31;

    // ------------------------------------------------------------
    // Reset values and masks
    // ------------------------------------------------------------
    localparam logic [31:0] IEN_RESET = 32'h0000_0000;
    localparam logic [31:0] IEN_AFTER_BUSRST = 32'h0000_0010;
    localparam logic [31:0] IEN_WMASK = 32'h7E00_7FFE;
    localparam logic [2:0] UFRM_LAST = 3'h7;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int SUSPEND_TIME_MS = 3;
    localparam int SUSPEND_CYCLES = SUSPEND_TIME_MS * 1000000 / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // Carrier from the link layer
    // ------------------------------------------------------------
    typedef struct packed {
        logic sof_seen;
        logic usof_seen;
        logic sof_synth;
        logic usof_synth;
        logic crc_bad;
        logic [10:0] frame;
        logic bus_reset;
        logic reset_end;
        logic line_j_idle;
        logic line_active;
        logic resume_end;
        logic remote_resume;
        logic high_speed;
    } udei_link_evt_type;

endpackage

// File: hw/udei_top.sv
// Event, interrupt and frame-number status logic with an AHB-Lite slave.
//
// The AHB-Lite slave port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module udei_top
#(
    parameter int SUSPEND_CYCLES = udei_pkg::SUSPEND_CYCLES
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire udei_pkg::udei_link_evt_type link_evt,
    input wire logic [udei_pkg::EP_COUNT-1:0] ep_src,
    input wire logic [udei_pkg::DMA_COUNT-1:0] dma_src,
    output logic [udei_pkg::EP_COUNT-1:0] ep_reset_strobe,
    output logic irq
);

    // ------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------
    generate
        if (SUSPEND_CYCLES < 1 || SUSPEND_CYCLES > 16777215)
        begin : g_bad_param
            $error("SUSPEND_CYCLES must lie in 1 to 2**24-1");
        end
    endgenerate

    localparam logic [23:0] SUSP_LAST = 24'(SUSPEND_CYCLES - 1);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic ap_valid;
    logic wr_pend_reg;
    logic [31:0] wr_addr_reg;
    logic [31:0] hrdata_reg;
    logic [31:0] rd_word;
    logic wr_ien;
    logic wr_iclr;
    logic wr_eprst;
    logic [31:0] ien_reg;
    logic [7:1] evt_reg;
    logic [7:1] evt_set;
    logic [7:1] evt_clr;
    logic [udei_pkg::EP_COUNT-1:0] ep_sta_reg;
    logic [udei_pkg::DMA_COUNT-1:0] dma_sta_reg;
    logic [udei_pkg::EP_COUNT-1:0] ep_rst_reg;
    logic [10:0] frame_reg;
    logic [2:0] ufrm_reg;
    logic ferr_reg;
    logic [23:0] idle_cnt_reg;
    logic suspended_reg;
    logic susp_hit;
    logic irq_reg;
    logic irq_next;
    logic sof_evt;
    logic usof_evt;
    logic [31:0] ista_word;
    logic [31:0] fnum_word;

    // ------------------------------------------------------------
    // AHB-Lite slave
    // ------------------------------------------------------------
    // Zero wait states; read data is sampled at the address phase so
    // that it stands from a flip-flop throughout the data phase.
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_reg;
    assign ap_valid = hsel && htrans[1] && hready;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 32'h0000_0000;
        end
        else
        begin
            wr_pend_reg <= ap_valid && hwrite;
            if (ap_valid)
            begin
                wr_addr_reg <= haddr;
            end
        end
    end

    assign wr_ien = wr_pend_reg && (wr_addr_reg == udei_pkg::ADDR_IEN);
    assign wr_iclr = wr_pend_reg && (wr_addr_reg == udei_pkg::ADDR_ICLR);
    assign wr_eprst = wr_pend_reg && (wr_addr_reg == udei_pkg::ADDR_EPRST);

    always_comb
    begin
        ista_word = 32'h0000_0000;
        ista_word[udei_pkg::SPEED_BIT] = link_evt.high_speed; // RULE6
        ista_word[7:1] = evt_reg;
        ista_word[udei_pkg::EP_LSB +: udei_pkg::EP_COUNT] = ep_sta_reg;
        ista_word[udei_pkg::DMA_LSB +: udei_pkg::DMA_COUNT] = dma_sta_reg;
        fnum_word = 32'h0000_0000;
        fnum_word[udei_pkg::UFRM_LSB +: udei_pkg::UFRM_W] = ufrm_reg;
        fnum_word[udei_pkg::FNUM_LSB +: udei_pkg::FNUM_W] = frame_reg;
        fnum_word[udei_pkg::FERR_BIT] = ferr_reg;
    end

    // Write-only and unmapped addresses read as zero.
    always_comb
    begin
        unique case (haddr)
            udei_pkg::ADDR_FNUM: rd_word = fnum_word;
            udei_pkg::ADDR_IEN: rd_word = ien_reg;
            udei_pkg::ADDR_ISTA: rd_word = ista_word;
            default: rd_word = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            hrdata_reg <= 32'h0000_0000;
        end
        else if (ap_valid && !hwrite)
        begin
            hrdata_reg <= rd_word;
        end
    end

    // ------------------------------------------------------------
    // Interrupt enable mask
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            ien_reg <= udei_pkg::IEN_RESET;
        end
        else if (link_evt.bus_reset)
        begin
            ien_reg <= udei_pkg::IEN_AFTER_BUSRST; // RULE5
        end
        else if (wr_ien)
        begin
            ien_reg <= hwdata & udei_pkg::IEN_WMASK; // RULE4
        end
    end

    // ------------------------------------------------------------
    // Suspend detection
    // ------------------------------------------------------------
    // The count restarts on any non-idle cycle, so only an unbroken
    // idle J period reaches the threshold.
    assign susp_hit = link_evt.line_j_idle && !suspended_reg
                      && (idle_cnt_reg == SUSP_LAST);

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            idle_cnt_reg <= 24'h00_0000;
        end
        else if (!link_evt.line_j_idle || suspended_reg || susp_hit)
        begin
            idle_cnt_reg <= 24'h00_0000;
        end
        else
        begin
            idle_cnt_reg <= idle_cnt_reg + 24'h00_0001; // RULE7
        end
    end

    // This clock is the always-on one; the controller clock that
    // software may gate never reaches this block. RULE14
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            suspended_reg <= 1'b0;
        end
        else if (susp_hit)
        begin
            suspended_reg <= 1'b1;
        end
        else if (link_evt.line_active || link_evt.bus_reset
                 || link_evt.remote_resume)
        begin
            suspended_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Event status bits
    // ------------------------------------------------------------
    // A SOF takes priority, so one packet never raises both bits.
    assign sof_evt = link_evt.sof_seen || link_evt.sof_synth;
    assign usof_evt = (link_evt.usof_seen || link_evt.usof_synth)
                      && !sof_evt; // RULE11

    always_comb
    begin
        evt_set = 7'h00;
        evt_set[udei_pkg::SUSP_BIT] = susp_hit; // RULE7
        evt_set[udei_pkg::USOF_BIT] = usof_evt; // RULE9
        evt_set[udei_pkg::SOF_BIT] = sof_evt; // RULE10
        evt_set[udei_pkg::ENDRST_BIT] = link_evt.reset_end; // RULE12
        evt_set[udei_pkg::WAKE_BIT] = suspended_reg && link_evt.line_active
                                      && !link_evt.remote_resume; // RULE13
        evt_set[udei_pkg::ENDRSM_BIT] = link_evt.resume_end; // RULE16
        evt_set[udei_pkg::UPRES_BIT] = link_evt.remote_resume; // RULE17
    end

    assign evt_clr = wr_iclr ? hwdata[7:1] : 7'h00;

    // Set wins over a clear in the same cycle; latching never looks at
    // the enable mask. RULE8
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            evt_reg <= 7'h00;
        end
        else
        begin
            evt_reg <= (evt_reg & ~evt_clr) | evt_set; // RULE20
        end
    end

    // ------------------------------------------------------------
    // Endpoint and DMA status
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rst_n || link_evt.bus_reset)
        begin
            ep_sta_reg <= 7'h00;
        end
        else
        begin
            ep_sta_reg <= ep_src
                & ien_reg[udei_pkg::EP_LSB +: udei_pkg::EP_COUNT]; // RULE18
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            dma_sta_reg <= 6'h00;
        end
        else
        begin
            dma_sta_reg <= dma_src
                & ien_reg[udei_pkg::DMA_LSB +: udei_pkg::DMA_COUNT]; // RULE19
        end
    end

    // One-cycle strobe per endpoint; the endpoint logic clears its own
    // state except the data toggle state. RULE22
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            ep_rst_reg <= 7'h00;
        end
        else
        begin
            ep_rst_reg <= wr_eprst ? hwdata[6:0] : 7'h00; // RULE21
        end
    end

    assign ep_reset_strobe = ep_rst_reg;

    // ------------------------------------------------------------
    // Frame number and microframe count
    // ------------------------------------------------------------
    // A corrupted SOF keeps the old frame number rather than loading
    // garbage; only the error flag reports it.
    always_ff @(posedge clk)
    begin
        if (!rst_n || link_evt.bus_reset)
        begin
            frame_reg <= 11'h000; // RULE1
            ufrm_reg <= 3'h0;
            ferr_reg <= 1'b0; // RULE2
        end
        else if (link_evt.sof_seen)
        begin
            if (!link_evt.crc_bad)
            begin
                frame_reg <= link_evt.frame; // RULE1
            end
            if (link_evt.high_speed)
            begin
                ufrm_reg <= 3'h0; // RULE10
            end
            ferr_reg <= link_evt.crc_bad; // RULE3
        end
        else if (link_evt.usof_seen)
        begin
            ufrm_reg <= (ufrm_reg == udei_pkg::UFRM_LAST) ? 3'h0
                        : ufrm_reg + 3'h1; // RULE23
            ferr_reg <= link_evt.crc_bad; // RULE2
        end
    end

    // ------------------------------------------------------------
    // Interrupt request
    // ------------------------------------------------------------
    assign irq_next = (|(evt_reg & ien_reg[7:1])) || (|ep_sta_reg)
                      || (|dma_sta_reg); // RULE24

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            irq_reg <= 1'b0;
        end
        else
        begin
            irq_reg <= irq_next; // RULE8
        end
    end

    assign irq = irq_reg;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_sof_frame;
        @(posedge clk) disable iff (!rst_n)
        link_evt.sof_seen && !link_evt.crc_bad && !link_evt.bus_reset
        |=> frame_reg == $past(link_evt.frame);
    endproperty
    a_sof_frame: assert property (p_sof_frame) // RULE1
        else $error("Frame number not loaded from SOF.");

    property p_crc_flag;
        @(posedge clk) disable iff (!rst_n)
        link_evt.sof_seen && link_evt.crc_bad && !link_evt.bus_reset
        |=> ferr_reg && evt_reg[udei_pkg::SOF_BIT];
    endproperty
    a_crc_flag: assert property (p_crc_flag) // RULE3
        else $error("CRC flag and SOF status not set together.");

    property p_busrst_clear;
        @(posedge clk) disable iff (!rst_n)
        link_evt.bus_reset |=> frame_reg == 11'h000 && !ferr_reg
            && ien_reg == udei_pkg::IEN_AFTER_BUSRST && ep_sta_reg == 7'h00;
    endproperty
    a_busrst_clear: assert property (p_busrst_clear) // RULE5
        else $error("Bus reset did not restore state.");

    property p_speed_read;
        @(posedge clk) disable iff (!rst_n)
        ap_valid && !hwrite && haddr == udei_pkg::ADDR_ISTA
        |=> hrdata[0] == $past(link_evt.high_speed);
    endproperty
    a_speed_read: assert property (p_speed_read) // RULE6
        else $error("Speed bit read wrong.");

    property p_suspend_time;
        @(posedge clk) disable iff (!rst_n)
        $rose(suspended_reg) |-> $past(idle_cnt_reg) == SUSP_LAST
            && evt_reg[udei_pkg::SUSP_BIT];
    endproperty
    a_suspend_time: assert property (p_suspend_time) // RULE7
        else $error("Suspend raised before idle time.");

    property p_irq_quiet;
        @(posedge clk) disable iff (!rst_n)
        (evt_reg & ien_reg[7:1]) == 7'h00 && ep_sta_reg == 7'h00
            && dma_sta_reg == 6'h00 |=> !irq;
    endproperty
    a_irq_quiet: assert property (p_irq_quiet) // RULE8
        else $error("Interrupt without enabled source.");

    property p_ufrm_step;
        @(posedge clk) disable iff (!rst_n)
        link_evt.usof_seen && !link_evt.sof_seen && !link_evt.bus_reset
        |=> ufrm_reg == 3'($past(ufrm_reg) + 3'h1)
            && frame_reg == $past(frame_reg);
    endproperty
    a_ufrm_step: assert property (p_ufrm_step) // RULE9
        else $error("Microframe count did not step.");

    property p_sof_hs;
        @(posedge clk) disable iff (!rst_n)
        link_evt.sof_seen && link_evt.high_speed |=> ufrm_reg == 3'h0;
    endproperty
    a_sof_hs: assert property (p_sof_hs) // RULE10
        else $error("Microframe count not cleared by SOF.");

    // A SOF cycle must leave a clear micro SOF status bit clear.
    property p_excl;
        @(posedge clk) disable iff (!rst_n)
        (link_evt.sof_seen || link_evt.sof_synth)
            && !evt_reg[udei_pkg::USOF_BIT] && !wr_iclr
        |=> !evt_reg[udei_pkg::USOF_BIT];
    endproperty
    a_excl: assert property (p_excl) // RULE11
        else $error("SOF and micro SOF raised together.");

    property p_wake;
        @(posedge clk) disable iff (!rst_n)
        suspended_reg && link_evt.line_active && !link_evt.remote_resume
        |=> evt_reg[udei_pkg::WAKE_BIT] && !suspended_reg;
    endproperty
    a_wake: assert property (p_wake) // RULE13
        else $error("Wake-up not flagged.");

    property p_clear;
        @(posedge clk) disable iff (!rst_n)
        wr_iclr && hwdata[udei_pkg::ENDRSM_BIT] && !link_evt.resume_end
        |=> !evt_reg[udei_pkg::ENDRSM_BIT];
    endproperty
    a_clear: assert property (p_clear) // RULE20
        else $error("Clear write did not clear status.");

    property p_eprst;
        @(posedge clk) disable iff (!rst_n)
        wr_eprst |=> ep_reset_strobe == $past(hwdata[6:0]) ##1
            ep_reset_strobe == 7'h00 || $past(wr_eprst);
    endproperty
    a_eprst: assert property (p_eprst) // RULE21
        else $error("Endpoint reset strobe wrong.");

    property p_ep_follow;
        @(posedge clk) disable iff (!rst_n)
        !link_evt.bus_reset |=> ep_sta_reg
            == ($past(ep_src) & $past(ien_reg[14:8]));
    endproperty
    a_ep_follow: assert property (p_ep_follow) // RULE18
        else $error("Endpoint status does not follow source.");

endmodule

`default_nettype wire

// File: verif/udei_host_model.sv
// Behavioural USB host side that drives the link event carrier.
`timescale 1ns/1ps
`default_nettype none

module udei_host_model
(
    input wire logic clk,
    output var udei_pkg::udei_link_evt_type link_evt
);
    logic hs = 1'b0;

    initial link_evt = '0;

    // ------------------------------------------------------------
    // Event drivers
    // ------------------------------------------------------------
    // The frame field is inverted once a packet is over, so a stale number
    // can never pass for a fresh one.
    task automatic send(input udei_pkg::udei_link_evt_type v, input int n);
        udei_pkg::udei_link_evt_type idle;
        v.high_speed = hs;
        idle = '0;
        idle.high_speed = hs;
        idle.frame = ~v.frame;
        link_evt <= v;
        repeat (n) @(posedge clk);
        link_evt <= idle;
        @(posedge clk);
    endtask

    task automatic frm(input logic s, input logic u, input logic [10:0] f, input logic bad);
        udei_pkg::udei_link_evt_type v;
        v = '0;
        v.sof_seen = s;
        v.usof_seen = u;
        v.frame = f;
        v.crc_bad = bad;
        send(v, 1);
    endtask

    task automatic line(input int k, input int n);
        udei_pkg::udei_link_evt_type v;
        v = '0;
        case (k)
            0: v.bus_reset = 1'b1;
            1: v.reset_end = 1'b1;
            2: v.line_j_idle = 1'b1;
            3: v.line_active = 1'b1;
            4: v.resume_end = 1'b1;
            5: v.remote_resume = 1'b1;
            6: v.sof_synth = 1'b1;
            7: v.usof_synth = 1'b1;
            default: v.frame = 11'h000;
        endcase
        send(v, n);
    endtask

    task automatic speed(input logic b);
        hs = b;
        line(8, 1);
    endtask
endmodule

`default_nettype wire

// File: verif/udei_top_test.sv
// Self-checking bench for the USB device event and interrupt block.
`timescale 1ns/1ps
`default_nettype none

module udei_top_test;
    localparam int SC = 20;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic rd_dp = 1'b0;
    logic [6:0] ep_src = 7'h00;
    logic [5:0] dma_src = 6'h00;
    wire logic hreadyout;
    wire logic hresp;
    wire logic [31:0] hrdata;
    wire logic [6:0] ep_reset_strobe;
    wire logic irq;
    udei_pkg::udei_link_evt_type link_evt;
    logic [31:0] exp_q[$];
    logic [31:0] m;
    logic [10:0] f;
    logic [6:0] e;
    logic [5:0] d;
    int miscompares = 0;
    int checks_done = 0;

    initial forever #5 clk = ~clk;

    udei_host_model host (.clk(clk), .link_evt(link_evt));

    udei_top #(.SUSPEND_CYCLES(SC)) dut (
        .clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .link_evt(link_evt),
        .ep_src(ep_src), .dma_src(dma_src), .ep_reset_strobe(ep_reset_strobe), .irq(irq)
    );

    // ------------------------------------------------------------
    // Checking and bus tasks
    // ------------------------------------------------------------
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
        checks_done++;
        if (s !== x)
        begin
            miscompares++;
            $display("BAD %s expected %h seen %h", n, x, s);
        end
    endtask

    task automatic results();
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] dat);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= dat;
        rd_dp <= !w;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd_dp <= 1'b0;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] dat);
        ahb(1'b1, a, dat);
    endtask

    task automatic rd(input logic [31:0] a, input logic [31:0] x);
        exp_q.push_back(x);
        ahb(1'b0, a, 32'h0);
    endtask

    function automatic logic [31:0] fn(logic b, logic [10:0] fr, logic [2:0] u);
        return {b, 17'h0, fr, u};
    endfunction

    // Read data is judged at the edge that closes the data phase.
    always @(posedge clk)
        if (rd_dp && hreadyout === 1'b1)
            chk("hrdata", hrdata, exp_q.pop_front());

    initial
    begin
        repeat (5000) @(posedge clk);
        miscompares++;
        results();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        void'($urandom(32'h3060001D));
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rd(udei_pkg::ADDR_FNUM, 32'h0);
        rd(udei_pkg::ADDR_IEN, udei_pkg::IEN_RESET);
        rd(udei_pkg::ADDR_ISTA, 32'h0);
        rd(udei_pkg::ADDR_ICLR, 32'h0);
        rd(32'hF803C020, 32'h0);
        m = $urandom;
        wr(udei_pkg::ADDR_IEN, m);
        rd(udei_pkg::ADDR_IEN, m & udei_pkg::IEN_WMASK);
        wr(udei_pkg::ADDR_IEN, 32'h0);
        host.speed(1'b1);
        rd(udei_pkg::ADDR_ISTA, 32'h1);
        f = 11'($urandom);
        host.frm(1'b1, 1'b0, f, 1'b0);
        rd(udei_pkg::ADDR_FNUM, fn(1'b0, f, 3'h0));
        repeat (3) host.frm(1'b0, 1'b1, ~f, 1'b0);
        rd(udei_pkg::ADDR_FNUM, fn(1'b0, f, 3'h3));
        host.frm(1'b1, 1'b0, ~f, 1'b0);
        rd(udei_pkg::ADDR_FNUM, fn(1'b0, ~f, 3'h0));
        host.frm(1'b1, 1'b0, f, 1'b1);
        rd(udei_pkg::ADDR_FNUM, fn(1'b1, ~f, 3'h0));
        rd(udei_pkg::ADDR_ISTA, 32'hD);
        chk("irq", irq, 32'h0);
        wr(udei_pkg::ADDR_IEN, 32'h8);
        repeat (3) @(posedge clk);
        chk("irq", irq, 32'h1);
        wr(udei_pkg::ADDR_ICLR, 32'h0);
        rd(udei_pkg::ADDR_ISTA, 32'hD);
        wr(udei_pkg::ADDR_ICLR, 32'hC);
        rd(udei_pkg::ADDR_ISTA, 32'h1);
        chk("irq", irq, 32'h0);
        host.frm(1'b1, 1'b1, f, 1'b0);
        rd(udei_pkg::ADDR_ISTA, 32'h9);
        host.frm(1'b0, 1'b1, ~f, 1'b1);
        rd(udei_pkg::ADDR_FNUM, fn(1'b1, f, 3'h1));
        host.line(7, 1);
        host.line(6, 1);
        rd(udei_pkg::ADDR_ISTA, 32'hD);
        wr(udei_pkg::ADDR_ICLR, 32'hFE);
        host.line(0, 4);
        host.line(1, 1);
        rd(udei_pkg::ADDR_IEN, udei_pkg::IEN_AFTER_BUSRST);
        rd(udei_pkg::ADDR_FNUM, 32'h0);
        rd(udei_pkg::ADDR_ISTA, 32'h11);
        chk("irq", irq, 32'h1);
        wr(udei_pkg::ADDR_ICLR, 32'h10);
        e = 7'($urandom) | 7'h01;
        d = 6'($urandom);
        ep_src <= e;
        dma_src <= d;
        wr(udei_pkg::ADDR_IEN, 32'h7E007F00);
        @(posedge clk);
        rd(udei_pkg::ADDR_ISTA, {1'b0, d, 10'h0, e, 8'h01});
        wr(udei_pkg::ADDR_IEN, 32'h00007F00);
        @(posedge clk);
        rd(udei_pkg::ADDR_ISTA, {17'h0, e, 8'h01});
        ep_src <= 7'h00;
        dma_src <= 6'h00;
        @(posedge clk);
        rd(udei_pkg::ADDR_ISTA, 32'h1);
        wr(udei_pkg::ADDR_EPRST, 32'h55);
        @(posedge clk);
        chk("strobe", ep_reset_strobe, 32'h55);
        @(posedge clk);
        chk("strobe", ep_reset_strobe, 32'h0);
        wr(udei_pkg::ADDR_EPRST, 32'h0);
        @(posedge clk);
        chk("strobe", ep_reset_strobe, 32'h0);
        host.line(2, SC - 5);
        rd(udei_pkg::ADDR_ISTA, 32'h1);
        host.line(2, SC + 5);
        rd(udei_pkg::ADDR_ISTA, 32'h3);
        host.line(5, 1);
        rd(udei_pkg::ADDR_ISTA, 32'h83);
        host.line(2, SC + 5);
        host.line(3, 1);
        rd(udei_pkg::ADDR_ISTA, 32'hA3);
        host.line(4, 1);
        rd(udei_pkg::ADDR_ISTA, 32'hE3);
        wr(udei_pkg::ADDR_IEN, 32'h20);
        repeat (3) @(posedge clk);
        chk("irq", irq, 32'h1);
        m = 32'hE3;
        for (int i = 1; i < 8; i++)
        begin
            m[i] = 1'b0;
            wr(udei_pkg::ADDR_ICLR, 32'h1 << i);
            rd(udei_pkg::ADDR_ISTA, m);
        end
        chk("irq", irq, 32'h0);
        results();
    end
endmodule

`default_nettype wire
